// ### bench/fault_meta_bench.sv
// Purpose: Directed bench for fault record and page metadata checks
// Assumes: Design inputs driven just after the rising edge
// Notes: Fault inputs held steady through each record
`timescale 1ns/1ps
module fault_meta_bench;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, fault_req = 1'b0;
    logic [7:0] addr = 8'h00, fault_vec = 8'h00;
    logic [31:0] wdata = 32'h0, fault_code_in = 32'h0000_0023, rdata, rec_data;
    logic [63:0] fault_lin = 64'h0000_1234_5678_9ABC, gpr_save_region = 64'h8000_1000;
    logic [63:0] rec_addr;
    logic rec_we, fault_reported, protection_fault;
    logic [2:0] page_grant;
    int err_count = 0, n_tests = 0, n_rep = 0;
    logic [63:0] qa[$];
    logic [31:0] qd[$];
    fault_meta fault_meta_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .fault_req(fault_req), .fault_vec(fault_vec),
        .fault_lin(fault_lin), .fault_code_in(fault_code_in), .gpr_save_region(gpr_save_region),
        .rec_we(rec_we), .rec_addr(rec_addr), .rec_data(rec_data),
        .fault_reported(fault_reported), .protection_fault(protection_fault),
        .page_grant(page_grant));
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        if (rec_we) begin
            qa.push_back(rec_addr);
            qd.push_back(rec_data);
        end
        if (fault_reported) n_rep++;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rd_reg
    // Queues cleared first so each record is judged alone
    task fault(input logic [7:0] v, input int words);
        qa.delete();
        qd.delete();
        n_rep = 0;
        @(posedge clk);
        fault_req <= 1'b1;
        fault_vec <= v;
        @(posedge clk);
        fault_req <= 1'b0;
        repeat (8) @(posedge clk);
        chk(qa.size(), words);
        chk(n_rep, words / 4);
    endtask : fault
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        report_and_stop;
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(8'h00, 32'h0000_0001);
        rd_reg(8'h08, 32'h0000_0000);
        rd_reg(8'hFC, 32'h0000_0000);
        fault(8'h0E, 0);
        wr_reg(8'h04, 32'h0000_0001);
        rd_reg(8'h08, 32'h0000_0010);
        wr_reg(8'h04, 32'h0000_0003);
        rd_reg(8'h08, 32'h0000_0010);
        $display("sizing done");
        fault(8'h0E, 4);
        chk(qa[0], 64'h8000_0FF0);
        chk({qd[1], qd[0]}, fault_lin);
        chk(qd[2], 32'h0000_0027);
        rd_reg(8'h28, 32'h0000_0027);
        rd_reg(8'h2C, 32'h0000_0000);
        rd_reg(8'h14, 32'h0000_1234);
        rd_reg(8'h34, 32'h8000_0FF0);
        rd_reg(8'h30, 32'h0000_0001);
        fault(8'h0D, 4);
        chk({qd[1], qd[0]}, 64'h0);
        chk(qd[2], 32'h0000_0023);
        fault(8'h03, 0);
        wr_reg(8'h00, 32'h0000_0000);
        rd_reg(8'h08, 32'h0000_0000);
        fault(8'h0E, 0);
        $display("fault record done");
        wr_reg(8'h40, 32'h0000_1010);
        rd_reg(8'h48, 32'h0000_0001);
        chk(protection_fault, 1'b1);
        wr_reg(8'h48, 32'h0000_0007);
        wr_reg(8'h40, 32'h0000_1020);
        rd_reg(8'h48, 32'h0000_0000);
        rd_reg(8'h40, 32'h0000_1020);
        for (int t = 0; t < 5; t++) begin
            wr_reg(8'h50, {16'h0, t[7:0], 8'h3D});
            rd_reg(8'h48, 32'h0000_0000);
            rd_reg(8'h50, {16'h0, t[7:0], 8'h3D});
        end
        rd_reg(8'h5C, 32'h0000_003D);
        chk(page_grant, 3'b101);
        wr_reg(8'h50, 32'h0000_0203);
        rd_reg(8'h50, 32'h0000_0203);
        chk(page_grant, 3'b011);
        wr_reg(8'h50, 32'h0000_0500);
        rd_reg(8'h48, 32'h0000_0004);
        wr_reg(8'h50, 32'h0000_0240);
        wr_reg(8'h48, 32'h0000_0007);
        rd_reg(8'h48, 32'h0000_0002);
        chk(protection_fault, 1'b1);
        wr_reg(8'h50, 32'h0000_0200);
        wr_reg(8'h54, 32'h0000_0100);
        wr_reg(8'h48, 32'h0000_0007);
        rd_reg(8'h48, 32'h0000_0002);
        wr_reg(8'h54, 32'h0000_0000);
        wr_reg(8'h48, 32'h0000_0007);
        wr_reg(8'h58, 32'h0000_0100);
        rd_reg(8'h48, 32'h0000_0002);
        wr_reg(8'h5C, 32'h0000_0000);
        wr_reg(8'h48, 32'h0000_0007);
        rd_reg(8'h48, 32'h0000_0000);
        chk(protection_fault, 1'b0);
        $display("metadata done");
        report_and_stop;
    end
endmodule : fault_meta_bench

// ### bench/fault_meta_monitor.sv
// Purpose: Port-level checker for the fault record writer
// Assumes: Four record words after a taken request, report pulse beside the last word
// Notes: Bound to fault_meta
`timescale 1ns/1ps
// ****************************************
// Checker
// ****************************************
module fault_meta_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fault_req,
    input wire logic [7:0] fault_vec,
    input wire logic [31:0] fault_code_in,
    input wire logic [63:0] gpr_save_region,
    input wire logic rec_we,
    input wire logic [63:0] rec_addr,
    input wire logic [31:0] rec_data,
    input wire logic fault_reported
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic rec_we_q1;
    logic rec_we_q2;
    logic rec_we_q3;
    logic third_w;
    // Third word of a record is the error code
    assign third_w = rec_we && rec_we_q1 && rec_we_q2 && !rec_we_q3;
    always_ff @(posedge clk) begin
        rec_we_q1 <= rec_we;
        rec_we_q2 <= rec_we_q1;
        rec_we_q3 <= rec_we_q2;
    end
    a_req_cause: assert property ($rose(rec_we) |-> $past(fault_req, 2)
        && ($past(fault_vec, 2) == 8'h0D || $past(fault_vec, 2) == 8'h0E))
        else $error("record without a qualified request");
    a_burst_four: assert property ($rose(rec_we) |-> (rec_we && !fault_reported) [*3]
        ##1 (rec_we && fault_reported) ##1 !rec_we)
        else $error("record is not four words with a report on the last");
    a_base_addr: assert property ($rose(rec_we) |-> rec_addr == $past(gpr_save_region, 2) - 64'h10)
        else $error("record base wrong");
    a_addr_step: assert property (rec_we && $past(rec_we) |-> rec_addr == $past(rec_addr) + 64'h4)
        else $error("record word address step wrong");
    a_rsvd_zero: assert property (fault_reported |-> rec_we && rec_data == 32'h0000_0000)
        else $error("reserved word not zero");
    a_gp_clear: assert property ($rose(rec_we) && $past(fault_vec, 2) == 8'h0D
        |-> rec_data == 32'h0000_0000 ##1 rec_data == 32'h0000_0000)
        else $error("address not cleared on protection fault");
    a_us_set: assert property (third_w && $past(fault_vec, 4) == 8'h0E |-> rec_data[2])
        else $error("user bit not set");
    a_code_pass: assert property (third_w |-> rec_data[1:0] == $past(fault_code_in[1:0], 4)
        && rec_data[5:3] == $past(fault_code_in[5:3], 4))
        else $error("code bits not passed");
endmodule : fault_meta_monitor

bind fault_meta fault_meta_monitor fault_meta_monitor_i (.clk(clk), .rst_n(rst_n),
    .fault_req(fault_req), .fault_vec(fault_vec), .fault_code_in(fault_code_in),
    .gpr_save_region(gpr_save_region), .rec_we(rec_we), .rec_addr(rec_addr),
    .rec_data(rec_data), .fault_reported(fault_reported));

// ### rtl/fault_meta.sv
// Purpose: Fault record formatting and page metadata checking
// Assumes: Plain register port, read data one cycle after strobe
// Notes: Fault requests arrive on ports from same-clock logic
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "fault_meta_regs.svh"
module fault_meta
    import fault_meta_pkg::*;
#(
    parameter logic [31:0] CAP_RESET = `CAP_RESET
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic fault_req,
    input wire logic [7:0] fault_vec,
    input wire logic [63:0] fault_lin,
    input wire logic [31:0] fault_code_in,
    input wire logic [63:0] gpr_save_region,
    output logic rec_we,
    output logic [63:0] rec_addr,
    output logic [31:0] rec_data,
    output logic fault_reported,
    output logic protection_fault,
    output logic [2:0] page_grant
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [31:0] cap;
        logic [31:0] sel;
        logic [63:0] faddr;
        logic [31:0] fcode;
        logic [2:0] rec_cnt;
        rec_state_e st;
        logic [63:0] rec_base;
        logic [31:0] rec_stat;
        logic [63:0] pb_lin;
        logic [63:0] sec;
        logic sec_rsvd_nz;
        logic [2:0] err;
        logic [31:0] rdata;
        logic rec_we;
        logic [63:0] rec_addr;
        logic [31:0] rec_data;
        logic reported;
        logic pfault;
        logic [2:0] grant;
        logic rd_mem;
    } state_s;

    state_s s_r;
    state_s s_nxt;
    logic [31:0] mem_rdata;
    logic [31:0] word_img;
    logic [1:0] mem_waddr;
    logic [31:0] misc_size;
    logic sec_type_bad;
    logic fault_ok;

    record_mem #(
        .WIDTH(32),
        .DEPTH(4)
    ) record_mem_i (
        .clk(clk),
        .we(s_r.st == st_write),
        .waddr(mem_waddr),
        .wdata(word_img),
        .raddr(addr[3:2]),
        .rdata(mem_rdata)
    );

    // ****************************************
    // Derived values
    // ****************************************
    always_comb begin
        misc_size = 32'h0000_0000;
        if (s_r.cap == 32'h0000_0000) begin
            misc_size = 32'h0000_0000;
        end else if (s_r.sel[0] && (s_r.sel[31:1] == 31'h0000_0000 || s_r.cap[31:1] == 31'h0)) begin
            // Only component 0 selected or known; higher ones take zero bytes
            misc_size = `FAULT_REC_SIZE;
        end else if (s_r.sel[0]) begin
            misc_size = `FAULT_REC_SIZE;
        end
    end

    assign sec_type_bad = s_r.sec[`SF_TYPE_MSB:`SF_TYPE_LSB] > 8'(kind_trimmed);
    assign fault_ok = s_r.cap[0] && s_r.sel[0]
                      && (fault_vec == `VEC_PROT || fault_vec == `VEC_PAGE);
    assign mem_waddr = s_r.rec_cnt[1:0];

    // Record image word by word
    always_comb begin
        word_img = 32'h0000_0000;
        unique case (s_r.rec_cnt[1:0])
            2'h0: word_img = s_r.faddr[31:0];
            2'h1: word_img = s_r.faddr[63:32];
            2'h2: word_img = s_r.fcode;
            2'h3: word_img = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.rec_we = 1'b0;
        s_nxt.reported = 1'b0;
        s_nxt.rd_mem = 1'b0;
        s_nxt.grant = s_r.sec[`SF_X:`SF_R];
        s_nxt.pfault = s_r.err != 3'h0;
        if (wr) begin
            unique case (addr)
                `REG_CAP_MASK: s_nxt.cap = wdata;
                `REG_SEL_MASK: s_nxt.sel = wdata;
                `REG_PB_W0: begin
                    s_nxt.pb_lin[31:0] = wdata;
                    // Sticky, so an aligned rewrite cannot hide an earlier fault
                    s_nxt.err[`ERR_PB_ALIGN] = s_r.err[`ERR_PB_ALIGN]
                                               | (wdata[`PB_ALIGN_BITS-1:0] != 5'h00);
                end
                `REG_PB_W1: s_nxt.pb_lin[63:32] = wdata;
                `REG_SEC_LO: s_nxt.sec[31:0] = wdata;
                `REG_SEC_HI: s_nxt.sec[63:32] = wdata;
                `REG_SEC_RSVD: s_nxt.sec_rsvd_nz = s_r.sec_rsvd_nz | (wdata != 32'h0);
                `REG_SEC_STAT: s_nxt.sec_rsvd_nz = 1'b0;
                `REG_PB_STAT: s_nxt.err = 3'h0; // Sets below win over this clear
                default: ;
            endcase
        end
        s_nxt.err[`ERR_SEC_RSVD] = s_nxt.err[`ERR_SEC_RSVD] | s_r.sec[7:6] != 2'h0
                                   | s_r.sec[63:16] != 48'h0 | s_r.sec_rsvd_nz;
        s_nxt.err[`ERR_SEC_TYPE] = s_nxt.err[`ERR_SEC_TYPE] | sec_type_bad;
        unique case (s_r.st)
            st_idle: begin
                if (fault_req && fault_ok) begin
                    s_nxt.faddr = (fault_vec == `VEC_PAGE) ? fault_lin : 64'h0;
                    s_nxt.fcode = fault_code_in;
                    if (fault_vec == `VEC_PAGE) begin
                        s_nxt.fcode[`EC_US_BIT] = 1'b1;
                    end
                    s_nxt.rec_base = gpr_save_region - 64'(`FAULT_REC_BELOW_GPR);
                    s_nxt.rec_cnt = 3'h0;
                    s_nxt.st = st_write;
                end
            end
            st_write: begin
                s_nxt.rec_we = 1'b1;
                s_nxt.rec_addr = s_r.rec_base + 64'({s_r.rec_cnt[1:0], 2'b00});
                s_nxt.rec_data = word_img;
                s_nxt.rec_cnt = s_r.rec_cnt + 3'h1;
                if (s_r.rec_cnt == 3'h3) begin
                    s_nxt.st = st_idle;
                    s_nxt.reported = 1'b1;
                    s_nxt.rec_stat = s_r.rec_stat + 32'h1;
                end
            end
        endcase
        s_nxt.rdata = 32'h0000_0000;
        if (rd) begin
            unique case (addr)
                `REG_CAP_MASK: s_nxt.rdata = s_r.cap;
                `REG_SEL_MASK: s_nxt.rdata = s_r.sel;
                `REG_MISC_SIZE: s_nxt.rdata = misc_size;
                `REG_FAULT_ADDR_LO: s_nxt.rdata = s_r.faddr[31:0];
                `REG_FAULT_ADDR_HI: s_nxt.rdata = s_r.faddr[63:32];
                `REG_FAULT_CODE: s_nxt.rdata = s_r.fcode;
                `REG_REC_W0, `REG_REC_W1, `REG_REC_W2, `REG_REC_W3: s_nxt.rd_mem = 1'b1;
                `REG_REC_STAT: s_nxt.rdata = s_r.rec_stat;
                `REG_REC_OFS: s_nxt.rdata = s_r.rec_base[31:0];
                `REG_PB_W0: s_nxt.rdata = s_r.pb_lin[31:0];
                `REG_PB_W1: s_nxt.rdata = s_r.pb_lin[63:32];
                `REG_PB_STAT: s_nxt.rdata = {29'h0, s_r.err};
                `REG_SEC_LO: s_nxt.rdata = s_r.sec[31:0];
                `REG_SEC_HI: s_nxt.rdata = s_r.sec[63:32];
                `REG_SEC_STAT: s_nxt.rdata = {26'h0, s_r.sec[`SF_PRB], s_r.sec[`SF_CHG],
                                              s_r.sec[`SF_PEND], s_r.sec[`SF_X:`SF_R]};
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.cap <= CAP_RESET;
            s_r.sel <= `SEL_RESET;
            s_r.st <= st_idle;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Record words come from memory; its read is already one cycle late
    assign rdata = s_r.rd_mem ? mem_rdata : s_r.rdata;
    assign rec_we = s_r.rec_we;
    assign rec_addr = s_r.rec_addr;
    assign rec_data = s_r.rec_data;
    assign fault_reported = s_r.reported;
    assign protection_fault = s_r.pfault;
    assign page_grant = s_r.grant;
endmodule : fault_meta

// ### rtl/fault_meta_pkg.sv
// Purpose: Types of the fault-info block
// Assumes: Nothing
// Notes: Constants live in the header
package fault_meta_pkg;
    typedef enum logic [7:0] {
        kind_control_struct,
        kind_thread_control,
        kind_regular,
        kind_version_array,
        kind_trimmed
    } page_kind_e;
    typedef enum logic [1:0] {
        st_idle,
        st_write
    } rec_state_e;
endpackage : fault_meta_pkg

// ### rtl/fault_meta_regs.svh
// Purpose: Offsets, field positions, reset values and codes of the fault-info block
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef FAULT_META_REGS_SVH
`define FAULT_META_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define REG_CAP_MASK 8'h00
`define REG_SEL_MASK 8'h04
`define REG_MISC_SIZE 8'h08
`define REG_FAULT_CTRL 8'h0C
`define REG_FAULT_ADDR_LO 8'h10
`define REG_FAULT_ADDR_HI 8'h14
`define REG_FAULT_CODE 8'h18
`define REG_REC_W0 8'h20
`define REG_REC_W1 8'h24
`define REG_REC_W2 8'h28
`define REG_REC_W3 8'h2C
`define REG_REC_STAT 8'h30
`define REG_REC_OFS 8'h34
`define REG_PB_W0 8'h40
`define REG_PB_W1 8'h44
`define REG_PB_STAT 8'h48
`define REG_SEC_LO 8'h50
`define REG_SEC_HI 8'h54
`define REG_SEC_RSVD 8'h58
`define REG_SEC_STAT 8'h5C

// ****************************************
// Layouts and codes
// ****************************************
`define FAULT_REC_SIZE 32'h0000_0010
`define FAULT_REC_BELOW_GPR 32'h0000_0010
`define FIELD_ADDR_OFS 8'h00
`define FIELD_CODE_OFS 8'h08
`define FIELD_RSVD_OFS 8'h0C
`define PB_ALIGN_BITS 5
`define PB_LIN_OFS 8'h00
`define PB_SRC_OFS 8'h08
`define PB_META_OFS 8'h10
`define PB_CTRL_OFS 8'h18
`define SEC_RSVD_BYTES 8'h38
`define VEC_PROT 8'h0D
`define VEC_PAGE 8'h0E
`define EC_US_BIT 2
`define EC_PK_BIT 5
`define SF_R 0
`define SF_W 1
`define SF_X 2
`define SF_PEND 3
`define SF_CHG 4
`define SF_PRB 5
`define SF_TYPE_LSB 8
`define SF_TYPE_MSB 15
`define CAP_RESET 32'h0000_0001
`define SEL_RESET 32'h0000_0000
`define ERR_PB_ALIGN 0
`define ERR_SEC_RSVD 1
`define ERR_SEC_TYPE 2
`endif

// ### rtl/record_mem.sv
// Purpose: Four-word store for the fault record image
// Assumes: One write port, one read port
// Notes: Read data registered
`timescale 1ns/1ps
module record_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : record_mem
